// ==== core/tsr_regs.sv ====
/*
  Result, interrupt and output register group of the touch sense converter.
  Register accesses arrive as byte requests on the link clock from the
  serial engine; front-end samples and calibration words arrive on clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: offset overflow raises interrupt only when overflow enable is 1.
// RL2: static calibration words are stored into static offsets automatically.
// RL3: host never runs static and dynamic calibration together.
// RL4: polarity 0 gives active-high interrupt, 1 gives active-low.
// RL5: mode 0 interrupts on first valid result, calibration done, overflow.
// RL6: mode 1 interrupts on consecutive threshold hits and on overflow.
// RL7: two-bit field selects averaging over 1, 2, 4 or 8 samples.
// RL8: missing history slots are filled with the first sample.
// RL9: with full history the last N samples are summed and divided by N.
// RL10: fourteen output bits at two addresses drive output pins directly.
// RL11: per-channel touch flags read as 1 once their interrupt occurred.
// RL12: bit 7 of second status register flags dynamic offset overflow.
// RL13: single-byte read of second status clears flags and interrupt.
// RL14: sequential read of second status leaves flags untouched.
// RL15: result is converter plus static plus dynamic offset, signed 16-bit.
// RL16: results sit at 0x07..0x22, high bytes first then low bytes.
// RL17: differential pair result goes into the odd channel's bytes.
// RL18: guard bit 0 at 0x23 resets to 0 and is read-write.
// RL19: nonvolatile writes accepted only while the guard bit is 0.
// RL20: host writes guard 1, 0, 1 at power-on.
// RL21: channel touch interrupt only when its enable bit is 1.
// RL22: interrupt holds asserted until a single-byte status read clears it.
module tsr_regs
  import tsr_pkg::*;
(
  // core clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // register port, link clock
  input  wire logic              link_clk,
  input  wire logic              link_req,
  input  var  tsr_req_t          link_cmd,
  output logic                   link_done,
  output logic [7:0]             link_rdata,
  // front end
  input  var  tsr_sample_t       sample,
  input  var  tsr_cal_t          cal,
  input  wire logic              run_start,
  input  wire logic              cal_done,
  input  wire logic              ofs_overflow,
  input  wire logic [NCH-1:0]    touch_irq_enable,
  input  wire logic [6:0]        diff_pair,
  input  wire logic [15:0]       touch_threshold,
  input  wire logic [3:0]        touch_count,
  input  wire logic              nvm_wr_req,
  // outputs
  output logic [NCH-1:0]         output_level,
  output logic                   irq_out,
  output logic                   nvm_wr_accept,
  output logic                   static_cal_enable
);

  typedef struct packed {
    logic                          req_tog;
    logic                          ack_s1;
    logic                          ack_s2;
    logic                          ack_seen;
    logic                          busy;
    logic                          done;
    logic [7:0]                    rdata;
    tsr_req_t                      cmd;
  } tsr_link_t;

  typedef struct packed {
    logic                          req_s1;
    logic                          req_s2;
    logic                          req_seen;
    logic                          ack_tog;
    logic [7:0]                    rdata;
    tsr_req_t                      cmd;
    logic [7:0]                    cfg2;
    logic [NCH-1:0]                out;
    logic                          guard;
    logic [NCH-1:0]                tflag;
    logic                          ovf;
    logic                          misc;
    logic                          first_seen;
    logic                          irq;
    logic                          nvm_ok;
    logic [NCH-1:0][15:0]          stat_ofs;
    logic [NCH-1:0][HIST-1:0][15:0] hist;
    logic [NCH-1:0][3:0]           fill;
    logic [NCH-1:0][3:0]           hits;
    logic [NCH-1:0][15:0]          result;
  } tsr_core_t;

  tsr_link_t l_q, l_d;
  tsr_core_t c_q, c_d;

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > $signed({2'b00, S16_MAX}))
      return S16_MAX;
    else if (v < $signed({2'b11, S16_MIN}))
      return S16_MIN;
    else
      return v[15:0];
  endfunction

  function automatic logic [15:0] avg_of(input logic [HIST-1:0][15:0] h,
                                         input logic [1:0] len);
    logic signed [18:0] acc;
    acc = '0;
    for (int i = 0; i < HIST; i++)
      if (i < (1 << len))
        acc = acc + 19'($signed(h[i]));
    acc = acc >>> len;
    return acc[15:0];
  endfunction

  // link side: hold the request, toggle toward core, wait for ack toggle
  always_comb
  begin
    l_d = l_q;
    l_d.done = 1'b0;
    l_d.ack_s1 = c_q.ack_tog;
    l_d.ack_s2 = l_q.ack_s1;
    if (link_req && !l_q.busy)
    begin
      l_d.cmd = link_cmd;
      l_d.req_tog = ~l_q.req_tog;
      l_d.busy = 1'b1;
    end
    if (l_q.ack_s2 != l_q.ack_seen)
    begin
      l_d.ack_seen = l_q.ack_s2;
      l_d.busy = 1'b0;
      l_d.done = 1'b1;
      l_d.rdata = c_q.rdata;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // core side
  always_comb
  begin
    logic        acc;
    logic        clr;
    logic [3:0]  ch;
    logic [15:0] raw;
    logic [7:0]  a;
    ch = 4'h0;
    raw = 16'h0000;
    c_d = c_q;
    c_d.req_s1 = l_q.req_tog;
    c_d.req_s2 = c_q.req_s1;
    acc = (c_q.req_s2 != c_q.req_seen);
    clr = 1'b0;
    a = l_q.cmd.addr;
    if (acc)
    begin
      c_d.req_seen = c_q.req_s2;
      c_d.ack_tog = ~c_q.ack_tog;
      c_d.rdata = 8'h00;
      if (l_q.cmd.write)
      begin
        case (a)
          OFS_CFG2:      c_d.cfg2 = l_q.cmd.wdata & CFG2_WMASK;
          OFS_OUT_LOW:   c_d.out[7:0] = l_q.cmd.wdata;                   // RL10
          OFS_OUT_HIGH:  c_d.out[13:8] = l_q.cmd.wdata[5:0] & OUT_HI_W;  // RL10
          OFS_NVM_GUARD: c_d.guard = l_q.cmd.wdata[0];                   // RL18
          default:       c_d.guard = c_q.guard;
        endcase
      end
      else
      begin
        case (a)
          OFS_CFG2:      c_d.rdata = c_q.cfg2;
          OFS_OUT_LOW:   c_d.rdata = c_q.out[7:0];
          OFS_OUT_HIGH:  c_d.rdata = {2'b00, c_q.out[13:8]};
          OFS_FLAGS_LOW: c_d.rdata = c_q.tflag[7:0];                     // RL11
          OFS_FLAGS_HI:  c_d.rdata = {c_q.ovf, 1'b0, c_q.tflag[13:8]};   // RL12
          OFS_NVM_GUARD: c_d.rdata = {7'h00, c_q.guard};
          default:
          begin
            if (a >= OFS_RES_HI && a < OFS_RES_LO)                       // RL16
              c_d.rdata = c_q.result[4'(a - OFS_RES_HI)][15:8];
            else if (a >= OFS_RES_LO && a <= OFS_RES_END)
              c_d.rdata = c_q.result[4'(a - OFS_RES_LO)][7:0];
          end
        endcase
        clr = (a == OFS_FLAGS_HI) && !l_q.cmd.seq;                       // RL13 RL14
      end
    end
    if (clr)
    begin
      c_d.tflag = '0;
      c_d.ovf = 1'b0;
      c_d.misc = 1'b0;
    end
    // calibration words stored without host help
    if (cal.valid && c_q.cfg2[B_STATIC_CAL] && cal.chan < 4'(NCH))       // RL2
      c_d.stat_ofs[cal.chan] = cal.value;
    if (run_start)
      c_d.first_seen = 1'b0;
    // events after the clear so a simultaneous set wins
    if (ofs_overflow)
      c_d.ovf = 1'b1;                                                    // RL12
    if (!c_q.cfg2[B_IRQ_MODE] && cal_done)
      c_d.misc = 1'b1;                                                   // RL5
    if (sample.valid && sample.chan < 4'(NCH))
    begin
      ch = diff_pair[sample.chan[3:1]] ? (sample.chan | 4'h1) : sample.chan; // RL17
      raw = sat16(18'($signed(sample.conv)) + 18'($signed(c_q.stat_ofs[ch]))
                  + 18'($signed(sample.dyn_ofs)));                       // RL15
      if (c_q.fill[ch] == 4'h0)
        c_d.hist[ch] = {HIST{raw}};                                      // RL8
      else
        c_d.hist[ch] = {c_q.hist[ch][HIST-2:0], raw};                    // RL9
      if (c_q.fill[ch] != HIST_FULL)
        c_d.fill[ch] = c_q.fill[ch] + 4'h1;
      c_d.result[ch] = avg_of(c_d.hist[ch], c_q.cfg2[B_AVG_HI:0]);      // RL7
      if (!c_q.first_seen && !c_q.cfg2[B_IRQ_MODE])
        c_d.misc = 1'b1;                                                 // RL5
      c_d.first_seen = 1'b1;
      if ($signed(c_d.result[ch]) > $signed(touch_threshold))
        c_d.hits[ch] = (c_q.hits[ch] == 4'hF) ? 4'hF : c_q.hits[ch] + 4'h1;
      else
        c_d.hits[ch] = 4'h0;
      if (c_q.cfg2[B_IRQ_MODE] && touch_irq_enable[ch] && touch_count != 4'h0
          && c_d.hits[ch] == touch_count)
        c_d.tflag[ch] = 1'b1;                                            // RL6 RL21
    end
    c_d.irq = ((|c_d.tflag) | c_d.misc | (c_d.ovf & c_d.cfg2[B_OVF_IRQ_EN]))
              ^ c_d.cfg2[B_IRQ_POL];                                     // RL1 RL4 RL22
    c_d.nvm_ok = nvm_wr_req && !c_d.guard;                               // RL19
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_q <= '0;
      c_q.cfg2 <= CFG2_RST;
      c_q.out <= OUT_RST;
    end
    else
      c_q <= c_d;
  end

  assign link_done = l_q.done;
  assign link_rdata = l_q.rdata;
  assign output_level = c_q.out;
  assign irq_out = c_q.irq;
  assign nvm_wr_accept = c_q.nvm_ok;
  assign static_cal_enable = c_q.cfg2[B_STATIC_CAL];

  logic any_pend;
  assign any_pend = (|c_q.tflag) | c_q.misc | (c_q.ovf & c_q.cfg2[B_OVF_IRQ_EN]);

  // core performs a register access on this edge
  logic take_now;
  assign take_now = (c_q.req_s2 != c_q.req_seen);

  sequence s_single_flag_read;
    (c_q.req_s2 != c_q.req_seen) && !l_q.cmd.write && !l_q.cmd.seq
      && l_q.cmd.addr == OFS_FLAGS_HI;
  endsequence

  a_ovf_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (c_q.ovf && !c_q.cfg2[B_OVF_IRQ_EN] && c_q.tflag == '0 && !c_q.misc)
      |-> (irq_out == c_q.cfg2[B_IRQ_POL]))                              // RL1
    else $error("overflow raised interrupt while disabled");

  a_irq_polarity: assert property (@(posedge clock) disable iff (!rst_n)
    irq_out == (any_pend ^ c_q.cfg2[B_IRQ_POL]))                         // RL4
    else $error("interrupt level does not follow polarity");

  a_single_clear: assert property (@(posedge clock) disable iff (!rst_n)
    s_single_flag_read and !ofs_overflow and !sample.valid and !cal_done
      |=> (c_q.tflag == '0 && !c_q.ovf))                                 // RL13
    else $error("single-byte status read did not clear flags");

  a_seq_keep: assert property (@(posedge clock) disable iff (!rst_n)
    ((c_q.req_s2 != c_q.req_seen) && l_q.cmd.seq && c_q.ovf) |=> c_q.ovf) // RL14
    else $error("sequential read cleared the overflow flag");

  a_ovf_sets: assert property (@(posedge clock) disable iff (!rst_n)
    ofs_overflow |=> c_q.ovf)                                            // RL12
    else $error("overflow event lost");

  a_out_write: assert property (@(posedge clock) disable iff (!rst_n)
    ((c_q.req_s2 != c_q.req_seen) && l_q.cmd.write && l_q.cmd.addr == OFS_OUT_LOW)
      |-> ##1 output_level[7:0] == $past(l_q.cmd.wdata))                 // RL10
    else $error("output bits did not take written value");

  a_nvm_guard: assert property (@(posedge clock) disable iff (!rst_n)
    c_q.guard |-> !nvm_wr_accept)                                        // RL19
    else $error("nonvolatile write accepted while guarded");

  a_nvm_open: assert property (@(posedge clock) disable iff (!rst_n)
    (!c_q.guard && $past(nvm_wr_req)) |-> nvm_wr_accept)                 // RL19
    else $error("nonvolatile write refused while unguarded");

  a_guard_write: assert property (@(posedge clock) disable iff (!rst_n)
    (take_now && l_q.cmd.write && l_q.cmd.addr == OFS_NVM_GUARD)
      |=> c_q.guard == $past(l_q.cmd.wdata[0]))                          // RL18
    else $error("guard bit did not take written value");

  a_out_high: assert property (@(posedge clock) disable iff (!rst_n)
    (take_now && l_q.cmd.write && l_q.cmd.addr == OFS_OUT_HIGH)
      |=> output_level[13:8] == $past(l_q.cmd.wdata[5:0]))               // RL10
    else $error("upper output bits did not take written value");

  a_cal_store: assert property (@(posedge clock) disable iff (!rst_n)
    (cal.valid && c_q.cfg2[B_STATIC_CAL] && cal.chan < 4'(NCH))
      |=> c_q.stat_ofs[$past(cal.chan)] == $past(cal.value))             // RL2
    else $error("calibration word not stored");

  a_flags_low: assert property (@(posedge clock) disable iff (!rst_n)
    (take_now && !l_q.cmd.write && l_q.cmd.addr == OFS_FLAGS_LOW)
      |=> c_q.rdata == $past(c_q.tflag[7:0]))                            // RL11
    else $error("first status byte does not show touch flags");

  a_flags_high: assert property (@(posedge clock) disable iff (!rst_n)
    (take_now && !l_q.cmd.write && l_q.cmd.addr == OFS_FLAGS_HI)
      |=> c_q.rdata == {$past(c_q.ovf), 1'b0, $past(c_q.tflag[13:8])})   // RL12
    else $error("second status byte does not show flags");

  a_first_result: assert property (@(posedge clock) disable iff (!rst_n)
    (sample.valid && sample.chan < 4'(NCH) && !c_q.first_seen
      && !c_q.cfg2[B_IRQ_MODE]) |=> c_q.misc)                            // RL5
    else $error("first result did not raise event");

  a_cal_event: assert property (@(posedge clock) disable iff (!rst_n)
    (cal_done && !c_q.cfg2[B_IRQ_MODE]) |=> c_q.misc)                    // RL5
    else $error("calibration done did not raise event");

  a_mode0_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (!c_q.cfg2[B_IRQ_MODE] && c_q.tflag == '0) |=> c_q.tflag == '0)      // RL6
    else $error("touch flag set outside threshold mode");

  a_touch_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (sample.valid && !touch_irq_enable[sample.chan] && !diff_pair[sample.chan[3:1]]
      && sample.chan < 4'(NCH) && !c_q.tflag[sample.chan])
      |=> !c_q.tflag[$past(sample.chan)])                                // RL21
    else $error("touch flag set on disabled channel");

  a_irq_hold: assert property (@(posedge clock) disable iff (!rst_n)
    ((c_q.tflag != '0) && !(take_now && !l_q.cmd.write && !l_q.cmd.seq
      && l_q.cmd.addr == OFS_FLAGS_HI)) |=> (c_q.tflag != '0))           // RL22
    else $error("touch flag dropped without a status read");

endmodule
`default_nettype wire

// ==== core/tsr_pkg.sv ====
/*
  Package for the touch sense result, interrupt and output register group:
  register offsets, field positions, reset values and carrier structs.
  Assumes a byte-wide register port fed by the serial protocol engine.
*/
package tsr_pkg;
  localparam int NCH = 14;
  localparam int HIST = 8;
  // register offsets
  localparam logic [7:0] OFS_CFG2      = 8'h02;
  localparam logic [7:0] OFS_OUT_LOW   = 8'h03;
  localparam logic [7:0] OFS_OUT_HIGH  = 8'h04;
  localparam logic [7:0] OFS_FLAGS_LOW = 8'h05;
  localparam logic [7:0] OFS_FLAGS_HI  = 8'h06;
  localparam logic [7:0] OFS_RES_HI    = 8'h07;
  localparam logic [7:0] OFS_RES_LO    = 8'h15;
  localparam logic [7:0] OFS_RES_END   = 8'h22;
  localparam logic [7:0] OFS_NVM_GUARD = 8'h23;
  // configuration 2 field positions
  localparam int B_STATIC_CAL = 7;
  localparam int B_OVF_IRQ_EN = 4;
  localparam int B_IRQ_POL    = 3;
  localparam int B_IRQ_MODE   = 2;
  localparam int B_AVG_HI     = 1;
  localparam int B_OVF_FLAG   = 7;
  localparam logic [7:0] CFG2_WMASK = 8'hBF;
  localparam logic [7:0] CFG2_RST   = 8'h00;
  localparam logic [13:0] OUT_RST   = 14'h0000;
  localparam logic [5:0] OUT_HI_W   = 6'h3F;
  localparam logic [15:0] S16_MAX   = 16'h7FFF;
  localparam logic [15:0] S16_MIN   = 16'h8000;
  localparam logic [3:0] HIST_FULL  = 4'h8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       seq;
  } tsr_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [15:0] conv;
    logic [15:0] dyn_ofs;
  } tsr_sample_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [15:0] value;
  } tsr_cal_t;
endpackage

// ==== verification/tsr_host_model.sv ====
/*
  Serial engine model on the link clock: one byte access at a time.
  Assumes the register group answers each request with a link_done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model
  import tsr_pkg::*;
(
  // link side
  input  wire logic       link_clk,
  input  wire logic       link_done,
  input  wire logic [7:0] link_rdata,
  output var  logic       link_req,
  output var  tsr_req_t   link_cmd
);
  initial
  begin
    link_req = 1'b0;
    link_cmd = '0;
  end

  // request pulse, command held until completion
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w,
                      input logic s, output logic [7:0] r, output logic ok);
    int n;
    n = 0;
    @(negedge link_clk);
    link_req = 1'b1;
    link_cmd = '{addr: a, wdata: d, write: w, seq: s};
    @(negedge link_clk);
    link_req = 1'b0;
    while (link_done !== 1'b1 && n < 200)
    begin
      @(negedge link_clk);
      n++;
    end
    ok = (link_done === 1'b1);
    r = link_rdata;
    @(negedge link_clk);
    // released lines must not keep the old value
    link_cmd = ~link_cmd;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
  Self-checking bench for the touch sense register group.
  Assumes the serial engine model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tsr_pkg::*;
;
  logic clock, rst_n, link_clk, link_req, link_done, irq_out, nvm_wr_req, nvm_wr_accept;
  logic static_cal_enable;
  logic [7:0] link_rdata;
  logic [2:0] ev;
  logic [NCH-1:0] touch_en, output_level;
  logic [6:0] diff_pair;
  tsr_req_t link_cmd;
  tsr_sample_t sample;
  tsr_cal_t cal;
  int mismatches, compares;

  tsr_regs tsr_regs_i (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .link_req(link_req), .link_cmd(link_cmd), .link_done(link_done),
    .link_rdata(link_rdata), .sample(sample), .cal(cal), .run_start(ev[0]),
    .cal_done(ev[1]), .ofs_overflow(ev[2]), .touch_irq_enable(touch_en),
    .diff_pair(diff_pair), .touch_threshold(16'h0100), .touch_count(4'h2),
    .nvm_wr_req(nvm_wr_req), .output_level(output_level), .irq_out(irq_out),
    .nvm_wr_accept(nvm_wr_accept), .static_cal_enable(static_cal_enable));
  tsr_host_model tsr_host_model_i (.link_clk(link_clk), .link_done(link_done),
    .link_rdata(link_rdata), .link_req(link_req), .link_cmd(link_cmd));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e);
    logic [7:0] r;
    logic ok;
    tsr_host_model_i.xfer(a, 8'h00, 1'b0, s, r, ok);
    check({15'h0, ok}, 16'h0001);
    check({8'h00, r}, {8'h00, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    tsr_host_model_i.xfer(a, d, 1'b1, 1'b0, r, ok);
    check({15'h0, ok}, 16'h0001);
  endtask

  task automatic pulse(input int i);
    @(negedge clock);
    ev[i] = 1'b1;
    @(negedge clock);
    ev[i] = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic put(input logic [3:0] ch, input logic [15:0] cv, input logic [15:0] dy);
    @(negedge clock);
    sample = '{valid: 1'b1, chan: ch, conv: cv, dyn_ofs: dy};
    @(negedge clock);
    sample.valid = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic report_and_stop();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    mismatches = 0;
    compares = 0;
    rst_n = 1'b0;
    ev = 3'h0;
    touch_en = 14'h0000;
    diff_pair = 7'h00;
    nvm_wr_req = 1'b0;
    sample = '0;
    cal = '0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(posedge link_clk);
    rd(OFS_OUT_LOW, 1'b0, 8'h00);
    rd(OFS_OUT_HIGH, 1'b0, 8'h00);
    rd(OFS_NVM_GUARD, 1'b0, 8'h00);
    wr(OFS_OUT_LOW, 8'hA5);
    wr(OFS_OUT_HIGH, 8'hFF);
    check({2'h0, output_level}, 16'h3FA5);
    rd(OFS_OUT_HIGH, 1'b0, 8'h3F);
    nvm_wr_req = 1'b1;
    wr(OFS_NVM_GUARD, 8'h01);
    check({15'h0, nvm_wr_accept}, 16'h0000);
    wr(OFS_NVM_GUARD, 8'h00);
    check({15'h0, nvm_wr_accept}, 16'h0001);
    wr(OFS_NVM_GUARD, 8'h01);
    rd(OFS_NVM_GUARD, 1'b0, 8'h01);
    check({15'h0, nvm_wr_accept}, 16'h0000);
    wr(OFS_CFG2, 8'h80);
    check({15'h0, static_cal_enable}, 16'h0001);
    @(negedge clock);
    cal = '{valid: 1'b1, chan: 4'h3, value: 16'h0010};
    @(negedge clock);
    cal.valid = 1'b0;
    wr(OFS_CFG2, 8'h00);
    put(4'h3, 16'h1234, 16'h0001);
    rd(8'h0A, 1'b0, 8'h12);
    rd(8'h18, 1'b0, 8'h45);
    put(4'h6, 16'h7FF0, 16'h0020);
    rd(8'h0D, 1'b0, 8'h7F);
    rd(8'h1B, 1'b0, 8'hFF);
    diff_pair = 7'h01;
    put(4'h0, 16'h0777, 16'h0000);
    rd(8'h08, 1'b0, 8'h07);
    rd(8'h16, 1'b0, 8'h77);
    wr(OFS_CFG2, 8'h01);
    put(4'h5, 16'h0064, 16'h0000);
    rd(8'h1A, 1'b0, 8'h64);
    put(4'h5, 16'h00C8, 16'h0000);
    rd(8'h1A, 1'b0, 8'h96);
    put(4'h5, 16'h012C, 16'h0000);
    rd(8'h1A, 1'b0, 8'hFA);
    rd(OFS_FLAGS_HI, 1'b0, 8'h00);
    wr(OFS_CFG2, 8'h10);
    pulse(2);
    check({15'h0, irq_out}, 16'h0001);
    rd(OFS_FLAGS_HI, 1'b1, 8'h80);
    check({15'h0, irq_out}, 16'h0001);
    rd(OFS_FLAGS_HI, 1'b0, 8'h80);
    check({15'h0, irq_out}, 16'h0000);
    rd(OFS_FLAGS_HI, 1'b0, 8'h00);
    wr(OFS_CFG2, 8'h00);
    pulse(2);
    check({15'h0, irq_out}, 16'h0000);
    rd(OFS_FLAGS_HI, 1'b0, 8'h80);
    wr(OFS_CFG2, 8'h08);
    check({15'h0, irq_out}, 16'h0001);
    pulse(1);
    check({15'h0, irq_out}, 16'h0000);
    rd(OFS_FLAGS_HI, 1'b0, 8'h00);
    check({15'h0, irq_out}, 16'h0001);
    wr(OFS_CFG2, 8'h00);
    pulse(0);
    put(4'h7, 16'h0010, 16'h0000);
    check({15'h0, irq_out}, 16'h0001);
    rd(OFS_FLAGS_HI, 1'b0, 8'h00);
    wr(OFS_CFG2, 8'h04);
    touch_en = 14'h0210;
    repeat (2) put(4'h2, 16'h0200, 16'h0000);
    check({15'h0, irq_out}, 16'h0000);
    repeat (2) put(4'h4, 16'h0200, 16'h0000);
    repeat (2) put(4'h9, 16'h0200, 16'h0000);
    check({15'h0, irq_out}, 16'h0001);
    rd(OFS_FLAGS_LOW, 1'b0, 8'h10);
    rd(OFS_FLAGS_HI, 1'b0, 8'h02);
    check({15'h0, irq_out}, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
